// ==== partial_and_early_page_read.sv ====
// Partial-page and early-data read control of a flash target
// Functional notes
// - One feature address holds both acceleration configurations.
// - Mode bits 2:1: 00 off (default), 01 early, 11 partial, 10 reserved.
// - Length is a byte count: low byte second, high byte third.
// - Early-only mode ignores the two length bytes.
// - Partial range runs from start column to start plus length minus one.
// - On NV-DDR2 the start column is forced even.
// - An end beyond the page is clipped to the last column.
// - Bytes outside the range are invalid; zero length invalidates all.
// - Partial read only for an enabled plain page read.
// - Cache, multi-plane and long-retry reads run without partial range.
// - Partial read is accepted during erase or program suspend.
// - Unique-ID, OTP and parameter page reads take no partial range, but partial mode still gives them early data.
// - Partial read carries early-data behaviour and its constraints.
// - Early data may be read once valid; no array command until done.
// - Status bit 6 shows data output may begin.
// - Status bit 5 stays low until the whole read completes.
// - Cache and long-retry reads never use early data.
`timescale 1ns/100ps
`default_nettype none
`include "read_accel_regs.svh"
module partial_and_early_page_read #(
	parameter int PAGE_BYTES    = `PAGE_BYTES_DEFAULT,
	parameter int ARRAY_READ_NS = `ARRAY_READ_TIME_NS,
	parameter int EARLY_DATA_NS = `EARLY_DATA_TIME_NS,
	parameter int READ_CYC      = ARRAY_READ_NS / `CLK_PERIOD_NS,
	parameter int EARLY_CYC     = EARLY_DATA_NS / `CLK_PERIOD_NS
) (
	input  wire logic                   clk,
	input  wire logic                   rst,
	input  wire read_accel_pkg::pins_s  pins,
	input  wire logic [7:0]             array_byte,
	input  wire logic                   nvddr2_mode,
	input  wire logic                   otp_mode,
	input  wire logic                   retry_long_tr,
	output logic [7:0]                  dq_out,
	output logic                        dq_oe_n,
	output logic [15:0]                 array_col,
	output logic [23:0]                 array_row,
	output logic                        array_read_start
);
	localparam int CW = $clog2(READ_CYC + 1);
	localparam logic [CW-1:0] LAST_CNT  = CW'(READ_CYC - 1);
	localparam logic [CW-1:0] EARLY_CNT = CW'(EARLY_CYC);

	read_accel_pkg::pins_s      sync1_r, sync2_r, prev_r;
	read_accel_pkg::cmd_state_e st_r, st_nxt;
	read_accel_pkg::out_sel_e   out_r, out_nxt;
	read_accel_pkg::accel_cfg_s cfg_r, cfg_nxt, shad_r, shad_nxt;
	logic [2:0]    idx_r, idx_nxt;
	logic          feat_ok_r, feat_ok_nxt;
	logic [15:0]   cmd_col_r, cmd_col_nxt, col_r, col_nxt;
	logic [15:0]   pstart_r, pstart_nxt, plen_r, plen_nxt;
	logic [23:0]   row_r, row_nxt;
	logic          start_r, start_nxt, busy_r, busy_nxt;
	logic          early_r, early_nxt, part_r, part_nxt;
	logic          rdy_r, rdy_nxt, array_done_flag_r, array_done_flag_nxt;
	logic [CW-1:0] cnt_r, cnt_nxt;
	logic [7:0]    dq_r, dq_nxt;
	logic          oe_n_r, oe_n_nxt;
	logic          we_rise, re_fall, cmd_stb, addr_stb, data_stb;
	logic          win_in, in_range, commit, go, go_plain, go_cache;
	logic [1:0]    mode;
	logic [7:0]    b;

	// Pins cross from the host's strobe timing; whole bundle is synced
	// together so data and strobes stay aligned.
	always_ff @(posedge clk) begin
		sync1_r <= pins;
		sync2_r <= sync1_r;
		prev_r  <= sync2_r;
	end

	assign we_rise  = sync2_r.we_n & ~prev_r.we_n;
	assign re_fall  = ~sync2_r.re_n & prev_r.re_n;
	assign cmd_stb  = we_rise & sync2_r.cle;
	assign addr_stb = we_rise & sync2_r.ale & ~sync2_r.cle;
	assign data_stb = we_rise & ~sync2_r.ale & ~sync2_r.cle;
	assign b        = sync2_r.dq;
	assign mode     = cfg_r.mode_byte[`MODE_MSB:`MODE_LSB];

	column_window #(
		.COL_W      (16),
		.PAGE_BYTES (PAGE_BYTES)
	) u_window (
		.clk       (clk),
		.rst       (rst),
		.start_col (pstart_r),
		.length    (plen_r),
		.col       (col_r),
		.in_range  (win_in),
		.end_col   ()
	);

	assign in_range = ~part_r | win_in;

	always_comb begin
		st_nxt      = st_r;
		out_nxt     = out_r;
		cfg_nxt     = cfg_r;
		shad_nxt    = shad_r;
		idx_nxt     = idx_r;
		feat_ok_nxt = feat_ok_r;
		cmd_col_nxt = cmd_col_r;
		col_nxt     = col_r;
		pstart_nxt  = pstart_r;
		plen_nxt    = plen_r;
		row_nxt     = row_r;
		start_nxt   = 1'b0;
		busy_nxt    = busy_r;
		early_nxt   = early_r;
		part_nxt    = part_r;
		cnt_nxt     = cnt_r;
		dq_nxt      = dq_r;
		commit      = 1'b0;
		go          = 1'b0;
		go_plain    = 1'b0;
		go_cache    = 1'b0;
		if (busy_r) begin
			cnt_nxt = cnt_r + CW'(1);
			if (cnt_r == LAST_CNT) begin
				busy_nxt = 1'b0;
			end
		end
		if (cmd_stb) begin
			st_nxt = read_accel_pkg::ST_IDLE;
			case (b)
				`CMD_RESET, `CMD_RESET_SYNC, `CMD_RESET_LUN: begin
					out_nxt  = read_accel_pkg::OUT_NONE;
					busy_nxt = 1'b0;
				end
				`CMD_STATUS, `CMD_STATUS_ENH: begin
					out_nxt = read_accel_pkg::OUT_STATUS;
				end
				`CMD_SET_FEAT: begin
					if (!busy_r) begin
						st_nxt = read_accel_pkg::ST_FADDR;
					end
				end
				`CMD_GET_FEAT: begin
					st_nxt = read_accel_pkg::ST_GADDR;
				end
				`CMD_READ: begin
					st_nxt  = read_accel_pkg::ST_RADDR;
					idx_nxt = 3'h0;
				end
				`CMD_CHGCOL, `CMD_CHGCOL_ENH: begin
					st_nxt  = read_accel_pkg::ST_CADDR;
					idx_nxt = 3'h0;
				end
				`CMD_CHGCOL_GO: begin
					col_nxt = cmd_col_r;
					out_nxt = read_accel_pkg::OUT_DATA;
				end
				`CMD_READ_GO, `CMD_MPLANE_GO: begin
					go       = ~busy_r;
					go_plain = (b == `CMD_READ_GO) &&
						(st_r == read_accel_pkg::ST_RADDR);
				end
				`CMD_CACHE_GO, `CMD_CACHE_LAST: begin
					go       = ~busy_r;
					go_cache = 1'b1;
				end
				`CMD_PARAM_PAGE, `CMD_UNIQUE_ID: begin
					go = ~busy_r;
				end
				default: begin
					st_nxt = read_accel_pkg::ST_IDLE;
				end
			endcase
		end else if (addr_stb) begin
			case (st_r)
				read_accel_pkg::ST_FADDR: begin
					feat_ok_nxt = (b == `FEAT_ADDR_ACCEL);
					st_nxt      = read_accel_pkg::ST_FDATA;
					idx_nxt     = 3'h0;
				end
				read_accel_pkg::ST_GADDR: begin
					feat_ok_nxt = (b == `FEAT_ADDR_ACCEL);
					out_nxt     = read_accel_pkg::OUT_FEAT;
					st_nxt      = read_accel_pkg::ST_IDLE;
					idx_nxt     = 3'h0;
				end
				read_accel_pkg::ST_RADDR, read_accel_pkg::ST_CADDR: begin
					case (idx_r)
						3'h0: cmd_col_nxt[7:0]  = b;
						3'h1: cmd_col_nxt[15:8] = b;
						3'h2: row_nxt[7:0]      = b;
						3'h3: row_nxt[15:8]     = b;
						3'h4: row_nxt[23:16]    = b;
						default: row_nxt        = row_r;
					endcase
					if (st_r == read_accel_pkg::ST_CADDR && idx_r[1]) begin
						row_nxt = row_r;
					end
					if (idx_r != 3'h7) begin
						idx_nxt = idx_r + 3'h1;
					end
				end
				default: begin
					st_nxt = st_r;
				end
			endcase
		end else if (data_stb && st_r == read_accel_pkg::ST_FDATA) begin
			case (idx_r[1:0])
				2'h0: shad_nxt.mode_byte = b;
				2'h1: shad_nxt.len[7:0]  = b;
				2'h2: shad_nxt.len[15:8] = b;
				default: begin
					commit = feat_ok_r;
					st_nxt = read_accel_pkg::ST_IDLE;
				end
			endcase
			idx_nxt = idx_r + 3'h1;
			if (commit) begin
				cfg_nxt      = shad_r;
				cfg_nxt.rsvd = b;
			end
		end
		// Suspend state is deliberately not a gate here
		if (go) begin
			busy_nxt  = 1'b1;
			cnt_nxt   = '0;
			start_nxt = 1'b1;
			out_nxt   = read_accel_pkg::OUT_NONE;
			part_nxt  = go_plain && (mode == `MODE_PARTIAL) &&
				!otp_mode && !retry_long_tr;
			early_nxt = ((mode == `MODE_EARLY) || part_nxt ||
				(mode == `MODE_PARTIAL)) &&
				!go_cache && !retry_long_tr;
			pstart_nxt = (part_nxt && nvddr2_mode) ?
				{cmd_col_r[15:1], 1'b0} : cmd_col_r;
			plen_nxt  = cfg_r.len;
			col_nxt   = pstart_nxt;
		end
		if (re_fall) begin
			case (out_r)
				read_accel_pkg::OUT_STATUS: begin
					dq_nxt = 8'h00;
					dq_nxt[`STAT_RDY_BIT]  = rdy_r;
					dq_nxt[`STAT_ARRAY_DONE_FLAG_BIT] = array_done_flag_r;
				end
				read_accel_pkg::OUT_DATA: begin
					dq_nxt  = (rdy_r && in_range) ? array_byte
						: `INVALID_BYTE;
					col_nxt = col_r + 16'h0001;
				end
				read_accel_pkg::OUT_FEAT: begin
					case (idx_r[1:0])
						2'h0: dq_nxt = {5'h00, mode, 1'b0};
						2'h1: dq_nxt = cfg_r.len[7:0];
						2'h2: dq_nxt = cfg_r.len[15:8];
						default: dq_nxt = cfg_r.rsvd;
					endcase
					if (!feat_ok_r) begin
						dq_nxt = 8'h00;
					end
					idx_nxt = idx_r + 3'h1;
				end
				default: begin
					dq_nxt = dq_r;
				end
			endcase
		end
		// Early data becomes readable before the array finishes
		array_done_flag_nxt = !busy_nxt;
		rdy_nxt  = !busy_nxt || (early_nxt && cnt_nxt >= EARLY_CNT);
		oe_n_nxt = !((out_r != read_accel_pkg::OUT_NONE) && !sync2_r.re_n);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_r      <= read_accel_pkg::ST_IDLE;
			out_r     <= read_accel_pkg::OUT_NONE;
			cfg_r     <= {`CFG_RSVD_RESET, `CFG_LEN_RESET, `CFG_MODE_RESET};
			shad_r    <= {`CFG_RSVD_RESET, `CFG_LEN_RESET, `CFG_MODE_RESET};
			idx_r     <= 3'h0;
			feat_ok_r <= 1'b0;
			cmd_col_r <= 16'h0000;
			col_r     <= 16'h0000;
			pstart_r  <= 16'h0000;
			plen_r    <= 16'h0000;
			row_r     <= 24'h000000;
			start_r   <= 1'b0;
			busy_r    <= 1'b0;
			early_r   <= 1'b0;
			part_r    <= 1'b0;
			cnt_r     <= '0;
			rdy_r     <= 1'b1;
			array_done_flag_r    <= 1'b1;
			dq_r      <= 8'h00;
			oe_n_r    <= 1'b1;
		end else begin
			st_r      <= st_nxt;
			out_r     <= out_nxt;
			cfg_r     <= cfg_nxt;
			shad_r    <= shad_nxt;
			idx_r     <= idx_nxt;
			feat_ok_r <= feat_ok_nxt;
			cmd_col_r <= cmd_col_nxt;
			col_r     <= col_nxt;
			pstart_r  <= pstart_nxt;
			plen_r    <= plen_nxt;
			row_r     <= row_nxt;
			start_r   <= start_nxt;
			busy_r    <= busy_nxt;
			early_r   <= early_nxt;
			part_r    <= part_nxt;
			cnt_r     <= cnt_nxt;
			rdy_r     <= rdy_nxt;
			array_done_flag_r    <= array_done_flag_nxt;
			dq_r      <= dq_nxt;
			oe_n_r    <= oe_n_nxt;
		end
	end

	assign dq_out           = dq_r;
	assign dq_oe_n          = oe_n_r;
	assign array_col        = col_r;
	assign array_row        = row_r;
	assign array_read_start = start_r;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	AST_MODE_DEFAULT: assert property ($fell(rst) |-> mode == `MODE_OFF)
		else $error("mode not off after reset");
	AST_CFG_ON_COMMIT: assert property (!$stable(cfg_r) |-> $past(commit))
		else $error("config changed without a full feature write");
	AST_PART_QUAL: assert property (start_r && part_r |->
		$past(mode) == `MODE_PARTIAL && !$past(otp_mode) &&
		!$past(retry_long_tr) && $past(b) == `CMD_READ_GO)
		else $error("partial read on a non-qualifying command");
	AST_EARLY_EXCL: assert property (start_r && early_r |->
		!$past(retry_long_tr) && $past(b) != `CMD_CACHE_GO &&
		$past(b) != `CMD_CACHE_LAST)
		else $error("early data on cache or long retry read");
	AST_PART_HAS_EARLY: assert property (start_r && part_r |-> early_r)
		else $error("partial read without early data");
	AST_ARRAY_DONE_FLAG_HOLD: assert property (start_r |-> !array_done_flag_r [*8])
		else $error("array done flag rose too early");
	AST_RDY_CAUSE: assert property (rdy_r && !array_done_flag_r |->
		early_r && cnt_r >= EARLY_CNT)
		else $error("data ready shown without early data");
	AST_EVEN_START: assert property (start_r && part_r &&
		$past(nvddr2_mode) |-> !array_col[0])
		else $error("odd start column on NV-DDR2");
	AST_INVALID_OUT: assert property (re_fall &&
		out_r == read_accel_pkg::OUT_DATA && !in_range |=>
		dq_out == `INVALID_BYTE)
		else $error("out of range byte not invalid");
	AST_EARLY_LEN_IGN: assert property (re_fall && rdy_r && !part_r &&
		out_r == read_accel_pkg::OUT_DATA |=> dq_out == $past(array_byte))
		else $error("length used outside partial read");

	COV_PARTIAL: cover property (start_r && part_r);
	COV_EARLY_WINDOW: cover property (rdy_r && !array_done_flag_r);
	COV_FEAT_READ: cover property (re_fall &&
		out_r == read_accel_pkg::OUT_FEAT);

endmodule : partial_and_early_page_read
`default_nettype wire

// ==== read_accel_regs.svh ====
// Constants for the read-acceleration feature block
`ifndef READ_ACCEL_REGS_SVH
`define READ_ACCEL_REGS_SVH

`define FEAT_ADDR_ACCEL     8'hF5
`define MODE_LSB            1
`define MODE_MSB            2
`define MODE_OFF            2'h0
`define MODE_EARLY          2'h1
`define MODE_RSVD           2'h2
`define MODE_PARTIAL        2'h3
`define CFG_MODE_RESET      8'h00
`define CFG_LEN_RESET       16'h0000
`define CFG_RSVD_RESET      8'h00
`define LEN_REQUIRED        16'h148C

`define CMD_READ            8'h00
`define CMD_READ_GO         8'h30
`define CMD_CACHE_GO        8'h31
`define CMD_CACHE_LAST      8'h3F
`define CMD_MPLANE_GO       8'h32
`define CMD_STATUS          8'h70
`define CMD_STATUS_ENH      8'h78
`define CMD_RESET           8'hFF
`define CMD_RESET_SYNC      8'hFC
`define CMD_RESET_LUN       8'hFA
`define CMD_CHGCOL          8'h05
`define CMD_CHGCOL_ENH      8'h06
`define CMD_CHGCOL_GO       8'hE0
`define CMD_SET_FEAT        8'hEF
`define CMD_GET_FEAT        8'hEE
`define CMD_PARAM_PAGE      8'hEC
`define CMD_UNIQUE_ID       8'hED

`define STAT_RDY_BIT        6
`define STAT_ARRAY_DONE_FLAG_BIT       5
`define INVALID_BYTE        8'hFF

`define CLK_PERIOD_NS       10
`define ARRAY_READ_TIME_NS  50000
`define EARLY_DATA_TIME_NS  25000
`define PAGE_BYTES_DEFAULT  16384

`endif

// ==== read_accel_pkg.sv ====
// Types shared by the read-acceleration block
`include "read_accel_regs.svh"
package read_accel_pkg;

	typedef struct packed {
		logic       cle;
		logic       ale;
		logic       we_n;
		logic       re_n;
		logic [7:0] dq;
	} pins_s;

	typedef struct packed {
		logic [7:0]  rsvd;
		logic [15:0] len;
		logic [7:0]  mode_byte;
	} accel_cfg_s;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_FADDR = 3'h1,
		ST_FDATA = 3'h2,
		ST_GADDR = 3'h3,
		ST_RADDR = 3'h4,
		ST_CADDR = 3'h5
	} cmd_state_e;

	typedef enum logic [1:0] {
		OUT_NONE   = 2'h0,
		OUT_STATUS = 2'h1,
		OUT_DATA   = 2'h2,
		OUT_FEAT   = 2'h3
	} out_sel_e;

endpackage : read_accel_pkg

// ==== column_window.sv ====
// Valid column range of a partial page read
`timescale 1ns/100ps
`default_nettype none
`include "read_accel_regs.svh"
module column_window #(
	parameter int COL_W      = 16,
	parameter int PAGE_BYTES = `PAGE_BYTES_DEFAULT
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [COL_W-1:0] start_col,
	input  wire logic [COL_W-1:0] length,
	input  wire logic [COL_W-1:0] col,
	output logic                  in_range,
	output logic [COL_W:0]        end_col
);
	localparam logic [COL_W:0] PAGE_MAX = (COL_W+1)'(PAGE_BYTES - 1);

	logic [COL_W:0] end_raw;

	always_comb begin
		end_raw = {1'b0, start_col} + {1'b0, length} - (COL_W+1)'(1);
		end_col = (end_raw > PAGE_MAX) ? PAGE_MAX : end_raw;
		in_range = (length != '0) &&
			({1'b0, col} >= {1'b0, start_col}) &&
			({1'b0, col} <= end_col);
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	AST_END_CLIPPED: assert property (end_col <= PAGE_MAX)
		else $error("partial end beyond last column");
	AST_LEN0_INVALID: assert property (length == '0 |-> !in_range)
		else $error("zero length left a byte valid");

endmodule : column_window
`default_nettype wire

// ==== nand_host_model.sv ====
// Host flash controller model driving the command and data pins
`timescale 1ns/100ps
`default_nettype none
`include "read_accel_regs.svh"
module nand_host_model (
	input  wire logic                   clk,
	input  wire logic [7:0]             dq_out,
	input  wire logic                   dq_oe_n,
	output var read_accel_pkg::pins_s   pins
);
	initial pins = '{1'h0, 1'h0, 1'h1, 1'h1, 8'h00};

	// Each strobe phase lasts 8 cycles, a 160 ns link period
	task automatic wr(input logic [1:0] ca, input logic [7:0] d);
		@(negedge clk);
		pins = '{ca[1], ca[0], 1'h0, 1'h1, d};
		repeat (8) @(negedge clk);
		pins.we_n = 1'h1;
		repeat (8) @(negedge clk);
		// A released bus must not keep showing the last byte
		pins = '{1'h0, 1'h0, 1'h1, 1'h1, ~d};
	endtask : wr

	// Sampled just before re_n rises; an undriven bus reads as unknown
	task automatic rd(output logic [7:0] d);
		@(negedge clk);
		pins.re_n = 1'h0;
		repeat (8) @(negedge clk);
		d = (dq_oe_n === 1'h0) ? dq_out : 8'hXX;
		pins.re_n = 1'h1;
		repeat (8) @(negedge clk);
	endtask : rd

	task automatic set_feat(input logic [7:0] m, lo, hi);
		wr(2'h2, `CMD_SET_FEAT);
		wr(2'h1, `FEAT_ADDR_ACCEL);
		wr(2'h0, m);
		wr(2'h0, lo);
		wr(2'h0, hi);
		wr(2'h0, 8'h00);
	endtask : set_feat

	task automatic get_feat(output logic [31:0] f);
		logic [7:0] b;
		wr(2'h2, `CMD_GET_FEAT);
		wr(2'h1, `FEAT_ADDR_ACCEL);
		for (int i = 0; i < 4; i++) begin
			rd(b);
			f = {f[23:0], b};
		end
	endtask : get_feat

	// Pages are plain, fully programmed and never used for bad-block scans
	task automatic page_read(input logic [7:0] go, input logic [15:0] c);
		if (go == `CMD_PARAM_PAGE || go == `CMD_UNIQUE_ID) begin
			wr(2'h2, go);
			wr(2'h1, 8'h00);
		end else if (go == `CMD_CACHE_LAST) begin
			wr(2'h2, go);
		end else begin
			wr(2'h2, `CMD_READ);
			wr(2'h1, c[7:0]);
			wr(2'h1, c[15:8]);
			wr(2'h1, 8'h12);
			wr(2'h1, 8'h34);
			wr(2'h1, 8'h05);
			wr(2'h2, go);
		end
	endtask : page_read

	task automatic status(output logic [7:0] s);
		wr(2'h2, `CMD_STATUS);
		rd(s);
	endtask : status

	task automatic chgcol(input logic [15:0] c);
		wr(2'h2, `CMD_CHGCOL);
		wr(2'h1, c[7:0]);
		wr(2'h1, c[15:8]);
		wr(2'h2, `CMD_CHGCOL_GO);
	endtask : chgcol

endmodule : nand_host_model
`default_nettype wire

// ==== partial_and_early_page_read_tb.sv ====
// Self-checking bench for the partial-page and early-data read block
`timescale 1ns/100ps
`default_nettype none
`include "read_accel_regs.svh"
module partial_and_early_page_read_tb;
	localparam int LAST = `PAGE_BYTES_DEFAULT - 1;
	localparam logic [7:0] GOS [7] = '{8'h31, 8'h32, 8'hEC, 8'hED,
		8'h30, 8'h30, 8'h3F};
	localparam logic [6:0] EARLY_TAB = 7'h1E;
	logic                  clk;
	logic                  rst;
	logic                  nvddr2_mode;
	logic                  otp_mode;
	logic                  retry_long_tr;
	read_accel_pkg::pins_s pins;
	logic [7:0]            dq_out;
	logic                  dq_oe_n;
	logic [15:0]           array_col;
	logic [23:0]           array_row;
	logic                  array_read_start;
	logic [7:0]            array_byte;
	logic [7:0]            st;
	logic [7:0]            lo;
	logic [7:0]            hi;
	logic [15:0]           c;
	logic [31:0]           f;
	logic [15:0]           start_seen;
	int                    s;
	int                    n_starts = 0;
	int                    n_mismatch = 0;
	int                    check_count = 0;
	int                    seed;

	function automatic logic [7:0] page_byte(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h5A;
	endfunction : page_byte

	function automatic logic [7:0] exp_byte(input int a, input logic part,
		input int b, input int len);
		int e;
		e = (b + len - 1 > LAST) ? LAST : b + len - 1;
		if (part && (len == 0 || a < b || a > e))
			return 8'hFF;
		return page_byte(a[15:0]);
	endfunction : exp_byte

	assign array_byte = page_byte(array_col);

	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end

	partial_and_early_page_read #(
		.ARRAY_READ_NS(8000),
		.EARLY_DATA_NS(4000)
	) u_dut (
		.clk(clk),
		.rst(rst),
		.pins(pins),
		.array_byte(array_byte),
		.nvddr2_mode(nvddr2_mode),
		.otp_mode(otp_mode),
		.retry_long_tr(retry_long_tr),
		.dq_out(dq_out),
		.dq_oe_n(dq_oe_n),
		.array_col(array_col),
		.array_row(array_row),
		.array_read_start(array_read_start)
	);

	nand_host_model u_host (
		.clk(clk),
		.dq_out(dq_out),
		.dq_oe_n(dq_oe_n),
		.pins(pins)
	);

	always @(negedge clk) begin
		if (array_read_start === 1'h1) begin
			n_starts = n_starts + 1;
			start_seen = array_col;
		end
	end

	task automatic chk(input string what, input logic [31:0] exp, got);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic close_out();
		if (n_mismatch == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : close_out

	task automatic poll(input int bitpos);
		for (int k = 0; k < 40; k++) begin
			u_host.status(st);
			if (st[bitpos] === 1'h1)
				break;
		end
	endtask : poll

	task automatic read_check(input int a, input logic part,
		input int b, input int len);
		logic [7:0] d;
		u_host.chgcol(a[15:0]);
		for (int i = 0; i < 4; i++) begin
			u_host.rd(d);
			chk("data", exp_byte(a + i, part, b, len), d);
		end
	endtask : read_check

	task automatic run_read(input logic [7:0] go, input logic [15:0] a,
		input logic early, input logic part, input int len, input int rc);
		int s0;
		int b;
		s0 = n_starts;
		b = (part && nvddr2_mode) ? {a[15:1], 1'h0} : a;
		u_host.page_read(go, a);
		chk("start", s0 + 1, n_starts);
		if (go != 8'hEC && go != 8'hED && go != 8'h3F) begin
			chk("column", b, start_seen);
			chk("row", 24'h053412, array_row);
		end
		poll(`STAT_RDY_BIT);
		chk("status", early ? 8'h40 : 8'h60, st);
		read_check(rc, part, b, len);
		// No further array command until the whole read is done
		poll(`STAT_ARRAY_DONE_FLAG_BIT);
		chk("done", 1, st[5]);
	endtask : run_read

	initial begin
		repeat (40000) @(posedge clk);
		n_mismatch++;
		close_out();
	end

	initial begin
		seed = 54;
		rst = 1'h1;
		nvddr2_mode = 1'h0;
		otp_mode = 1'h0;
		retry_long_tr = 1'h0;
		repeat (2) @(posedge clk);
		@(negedge clk);
		rst = 1'h0;
		chk("oe", 1, dq_oe_n);
		u_host.get_feat(f);
		chk("feature", 0, f);
		for (int m = 0; m < 3; m++) begin
			lo = 8'($random(seed));
			hi = 8'($random(seed));
			u_host.set_feat({5'h00, m[1:0], 1'h0}, lo, hi);
			u_host.get_feat(f);
			chk("feature", {5'h00, m[1:0], 1'h0, lo, hi, 8'h00}, f);
			c = 16'($random(seed));
			c = c & 16'h3FF0;
			run_read(8'h30, c, m == 1, 1'h0, 0, c);
		end
		nvddr2_mode = 1'h1;
		c = 16'($random(seed));
		c = (c & 16'h1FFF) | 16'h0801;
		s = {c[15:1], 1'h0};
		u_host.set_feat(8'h06, 8'h8C, 8'h14);
		run_read(8'h30, c, 1'h1, 1'h1, 5260, s - 2);
		read_check(s + 5258, 1'h1, s, 5260);
		nvddr2_mode = 1'h0;
		run_read(8'h30, 16'h3FFC, 1'h1, 1'h1, 5260, 16'h3FFA);
		for (int k = 0; k < 7; k++) begin
			otp_mode = (k == 4);
			retry_long_tr = (k == 5);
			run_read(GOS[k], 16'h0800, EARLY_TAB[k], 1'h0, 0, 16'h0100);
		end
		otp_mode = 1'h0;
		retry_long_tr = 1'h0;
		// Length zero breaks the host's duty on purpose
		u_host.set_feat(8'h06, 8'h00, 8'h00);
		run_read(8'h30, 16'h0400, 1'h1, 1'h1, 0, 16'h0400);
		close_out();
	end

endmodule : partial_and_early_page_read_tb
`default_nettype wire
